/* File: rtl/sfa_pkg.sv */
// sfa_pkg: shared constants for the status-flag and data-addressing slice
// assumes: used by sfa_alu_flags and sfa_core on one 20 MHz core clock
// Summary of operation
// RULE1 - top bit of arithmetic status reads zero, writes to it ignored
// RULE2 - timeout indicator set at power-up, watchdog clear or sleep; cleared on timeout
// RULE3 - power-down indicator set at power-up or watchdog clear; cleared by sleep
// RULE4 - negative flag takes result msb after arithmetic operation
// RULE5 - signed overflow flag set when sign bit changes by overflow, else cleared
// RULE6 - zero flag set when arithmetic or logic result is zero, else cleared
// RULE7 - add/subtract set nibble carry on carry out of bit 3, else clear
// RULE8 - add/subtract set carry on carry out of msb, else clear
// RULE9 - subtraction adds two's complement; carries mean no borrow
// RULE10 - rotate through carry loads carry with the bit shifted out
// RULE11 - bit and byte instructions take 8-bit address from opcode low byte
// RULE12 - access select one joins bank select register with opcode address
// RULE13 - access select zero maps opcode address into access bank, bank ignored
// RULE14 - long move uses full 14-bit opcode address, bank select ignored
// RULE15 - destination select one writes source register, zero writes working register
// RULE16 - three pointer pairs of two bytes hold 14-bit address; top two unused
// RULE17 - virtual indirect operand accesses memory at its pointer pair address
// RULE18 - indirect address uses only 14-bit pointer, not bank or access bit
// RULE19 - post inc/dec adjust pointer after access; pre-increment adjusts before
// RULE20 - working offset addresses pointer plus signed working value, changing neither
// RULE21 - pointer adjust spans whole 14 bits and never touches status flags
// RULE22 - flag-affecting op aimed at status updates flags, result not written
// RULE23 - power-on reset clears five flags, sets timeout and power-down indicators

package sfa_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFS_ARITH_STATUS = 12'h000;
	localparam logic [11:0] OFS_BANK_SELECT = 12'h004;
	localparam logic [11:0] OFS_PTR_BASE = 12'h010;
	localparam logic [11:0] OFS_PTR_STRIDE = 12'h008;
	localparam logic [11:0] OFS_PTR_HIGH = 12'h004;

	// ----------------------------------------
	// arithmetic status fields
	// ----------------------------------------
	localparam int unsigned BIT_UNUSED = 7;
	localparam int unsigned BIT_WDT_TMO = 6;
	localparam int unsigned BIT_PWRDN = 5;
	localparam int unsigned BIT_NEG = 4;
	localparam int unsigned BIT_SOVF = 3;
	localparam int unsigned BIT_ZERO = 2;
	localparam int unsigned BIT_NIB_C = 1;
	localparam int unsigned BIT_CARRY = 0;
	localparam logic [4:0] ARITH_FLAGS_POR = 5'h00;
	localparam logic WDT_TMO_POR = 1'b1;
	localparam logic PWRDN_POR = 1'b1;

	// ----------------------------------------
	// addressing constants
	// ----------------------------------------
	localparam logic [5:0] BANK_SELECT_POR = 6'h00;
	localparam logic [13:0] PTR_POR = 14'h0000;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [5:0] ACCESS_LOW_BANK = 6'h00;
	localparam logic [5:0] ACCESS_HIGH_BANK = 6'h3f;

	// ----------------------------------------
	// operation and address modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_ADD,
		OP_SUB,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_ROT_LEFT_C,
		OP_ROT_RIGHT_C,
		OP_PASS
	} sfa_op_t;

	typedef enum logic [2:0] {
		AM_DIRECT,
		AM_LONG,
		AM_INDIRECT,
		AM_POST_INC,
		AM_POST_DEC,
		AM_PRE_INC,
		AM_WORK_OFS
	} sfa_amode_t;

endpackage

/* File: rtl/sfa_alu_flags.sv */
// sfa_alu_flags: combinational result and flag generation for one operation
// assumes: operands and carry in are stable for the cycle of use
`timescale 1ns/1ps

module sfa_alu_flags
(
	// operation
	input logic [2:0] op_i,
	input logic [7:0] a_i,
	input logic [7:0] b_i,
	input logic carry_i,
	// result and flags
	output logic [7:0] res_o,
	output logic neg_o,
	output logic sovf_o,
	output logic zero_o,
	output logic nib_c_o,
	output logic carry_o,
	output logic arith_o,
	output logic rot_o
);

	// ----------------------------------------
	// adder
	// ----------------------------------------
	wire is_sub = (op_i == sfa_pkg::OP_SUB);
	// RULE9 two's complement subtract
	wire [7:0] b_eff = is_sub ? ~b_i : b_i;
	wire [8:0] sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, is_sub};
	wire [4:0] low_sum = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};

	assign arith_o = (op_i == sfa_pkg::OP_ADD) || is_sub;
	assign rot_o = (op_i == sfa_pkg::OP_ROT_LEFT_C) || (op_i == sfa_pkg::OP_ROT_RIGHT_C);

	// ----------------------------------------
	// result select
	// ----------------------------------------
	assign res_o = arith_o ? sum[7:0] :
		(op_i == sfa_pkg::OP_AND) ? (a_i & b_i) :
		(op_i == sfa_pkg::OP_OR) ? (a_i | b_i) :
		(op_i == sfa_pkg::OP_XOR) ? (a_i ^ b_i) :
		(op_i == sfa_pkg::OP_ROT_LEFT_C) ? {a_i[6:0], carry_i} :
		(op_i == sfa_pkg::OP_ROT_RIGHT_C) ? {carry_i, a_i[7:1]} : a_i;

	// RULE4 sign from msb
	assign neg_o = res_o[7];
	// RULE5 sign change overflow
	assign sovf_o = (a_i[7] == b_eff[7]) && (sum[7] != a_i[7]);
	// RULE6 zero detect
	assign zero_o = (res_o == 8'h00);
	// RULE7 carry from bit 3
	assign nib_c_o = low_sum[4];
	// RULE8 carry from msb, RULE10 rotate out bit
	assign carry_o = (op_i == sfa_pkg::OP_ROT_LEFT_C) ? a_i[7] :
		(op_i == sfa_pkg::OP_ROT_RIGHT_C) ? a_i[0] : sum[8];

endmodule // sfa_alu_flags

/* File: rtl/sfa_core.sv */
// sfa_core: arithmetic status flags, pointer pairs and data address forming
// assumes: decoder/alu drive one-cycle strobes; data memory takes the address
`timescale 1ns/1ps

module sfa_core #(
	parameter int unsigned PTR_COUNT = 3
)
(
	// clock and power-on reset
	input logic clock_i,
	input logic srst_i,
	// apb slave
	input logic psel_i,
	input logic penable_i,
	input logic pwrite_i,
	input logic [11:0] paddr_i,
	input logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// alu operation
	input logic op_valid_i,
	input logic [2:0] op_kind_i,
	input logic [7:0] op_a_i,
	input logic [7:0] op_b_i,
	input logic dest_sel_i,
	input logic dest_is_status_i,
	output logic [7:0] result_o,
	output logic file_we_o,
	output logic wreg_we_o,
	// power events
	input logic wdt_clear_i,
	input logic sleep_i,
	input logic wdt_timeout_i,
	// address request
	input logic addr_req_i,
	input logic [2:0] amode_i,
	input logic [7:0] opcode_addr_i,
	input logic access_sel_i,
	input logic [13:0] long_addr_i,
	input logic [1:0] ptr_sel_i,
	input logic [7:0] working_i,
	output logic [13:0] data_addr_o,
	output logic addr_valid_o,
	// status view
	output logic [7:0] arith_status_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic neg_q, sovf_q, zero_q, nib_c_q, carry_q;
	logic wdt_tmo_q, pwrdn_q;
	logic [5:0] bank_q;
	logic [13:0] ptr_q [PTR_COUNT];
	logic [13:0] ptr_d [PTR_COUNT];
	logic [7:0] result_q;
	logic file_we_q, wreg_we_q;
	logic [13:0] data_addr_q;
	logic addr_valid_q;
	logic [31:0] prdata_q;

	function automatic logic [13:0] ptr_add(input logic [13:0] p, input logic [7:0] ofs);
		ptr_add = p + {{6{ofs[7]}}, ofs};
	endfunction

	function automatic logic [11:0] ptr_ofs(input int unsigned idx, input logic high);
		ptr_ofs = sfa_pkg::OFS_PTR_BASE + 12'(idx) * sfa_pkg::OFS_PTR_STRIDE
			+ (high ? sfa_pkg::OFS_PTR_HIGH : 12'h000);
	endfunction

	// ----------------------------------------
	// alu flags
	// ----------------------------------------
	logic [7:0] alu_res;
	logic alu_neg, alu_sovf, alu_zero, alu_nib_c, alu_carry, alu_arith, alu_rot;

	sfa_alu_flags u_alu (
		.op_i(op_kind_i),
		.a_i(op_a_i),
		.b_i(op_b_i),
		.carry_i(carry_q),
		.res_o(alu_res),
		.neg_o(alu_neg),
		.sovf_o(alu_sovf),
		.zero_o(alu_zero),
		.nib_c_o(alu_nib_c),
		.carry_o(alu_carry),
		.arith_o(alu_arith),
		.rot_o(alu_rot)
	);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire apb_setup = psel_i && !penable_i;
	wire apb_access = psel_i && penable_i;
	wire apb_wr = apb_access && pwrite_i;
	wire hit_status = (paddr_i == sfa_pkg::OFS_ARITH_STATUS);
	wire hit_bank = (paddr_i == sfa_pkg::OFS_BANK_SELECT);
	logic hit_ptr;
	logic [31:0] rd_mux;

	// RULE1 msb held at zero
	assign arith_status_o = {1'b0, wdt_tmo_q, pwrdn_q, neg_q, sovf_q, zero_q, nib_c_q,
		carry_q};

	always_comb
	begin
		hit_ptr = 1'b0;
		rd_mux = 32'h0000_0000;
		if (hit_status)
			rd_mux = {24'h00_0000, arith_status_o};
		if (hit_bank)
			rd_mux = {26'h000_0000, bank_q};
		for (int i = 0; i < PTR_COUNT; i++)
		begin
			if (paddr_i == ptr_ofs(i, 1'b0))
			begin
				hit_ptr = 1'b1;
				rd_mux = {24'h00_0000, ptr_q[i][7:0]};
			end
			// RULE16 upper two bits read zero
			if (paddr_i == ptr_ofs(i, 1'b1))
			begin
				hit_ptr = 1'b1;
				rd_mux = {26'h000_0000, ptr_q[i][13:8]};
			end
		end
	end

	wire hit_any = hit_status || hit_bank || hit_ptr;
	assign pready_o = 1'b1;
	assign pslverr_o = apb_access && !hit_any;
	assign prdata_o = prdata_q;

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			prdata_q <= 32'h0000_0000;
		else if (apb_setup)
			prdata_q <= rd_mux;
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			bank_q <= sfa_pkg::BANK_SELECT_POR;
		else if (apb_wr && hit_bank)
			bank_q <= pwdata_i[5:0];
	end

	// ----------------------------------------
	// arithmetic flags
	// ----------------------------------------
	always_ff @(posedge clock_i)
	begin
		// RULE23 power-on values
		if (srst_i)
			{neg_q, sovf_q, zero_q, nib_c_q, carry_q} <= sfa_pkg::ARITH_FLAGS_POR;
		else if (op_valid_i)
		begin
			// RULE22 flags follow the operation
			neg_q <= alu_neg;
			zero_q <= alu_zero;
			if (alu_arith)
			begin
				sovf_q <= alu_sovf;
				nib_c_q <= alu_nib_c;
				carry_q <= alu_carry;
			end
			// RULE10 rotate loads carry
			if (alu_rot)
				carry_q <= alu_carry;
		end
		// RULE1 bit 7 write dropped
		else if (apb_wr && hit_status)
			{neg_q, sovf_q, zero_q, nib_c_q, carry_q} <= pwdata_i[4:0];
	end

	// ----------------------------------------
	// timeout and power-down indicators
	// ----------------------------------------
	// RULE2 timeout indicator
	wire wdt_tmo_d = wdt_timeout_i ? 1'b0 : (wdt_clear_i || sleep_i) ? 1'b1 : wdt_tmo_q;
	// RULE3 power-down indicator
	wire pwrdn_d = wdt_clear_i ? 1'b1 : sleep_i ? 1'b0 : pwrdn_q;

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			wdt_tmo_q <= sfa_pkg::WDT_TMO_POR;
			pwrdn_q <= sfa_pkg::PWRDN_POR;
		end
		else
		begin
			wdt_tmo_q <= wdt_tmo_d;
			pwrdn_q <= pwrdn_d;
		end
	end

	// ----------------------------------------
	// result write-back
	// ----------------------------------------
	// RULE22 status destination swallows result
	wire status_dest = dest_sel_i && dest_is_status_i;

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			result_q <= 8'h00;
			file_we_q <= 1'b0;
			wreg_we_q <= 1'b0;
		end
		else
		begin
			if (op_valid_i)
				result_q <= alu_res;
			// RULE15 destination select
			file_we_q <= op_valid_i && dest_sel_i && !status_dest;
			wreg_we_q <= op_valid_i && !dest_sel_i;
		end
	end

	assign result_o = result_q;
	assign file_we_o = file_we_q;
	assign wreg_we_o = wreg_we_q;

	// ----------------------------------------
	// address forming
	// ----------------------------------------
	wire ptr_ok = (int'(ptr_sel_i) < PTR_COUNT);
	wire [13:0] ptr_cur = ptr_ok ? ptr_q[ptr_sel_i] : 14'h0000;
	// RULE21 whole-pair step
	wire [13:0] ptr_inc = ptr_add(ptr_cur, 8'h01);
	wire [13:0] ptr_dec = ptr_add(ptr_cur, 8'hff);
	// RULE20 signed working offset
	wire [13:0] ptr_work = ptr_add(ptr_cur, working_i);
	// RULE13 access bank map
	wire [5:0] access_bank = (opcode_addr_i < sfa_pkg::ACCESS_SPLIT) ?
		sfa_pkg::ACCESS_LOW_BANK : sfa_pkg::ACCESS_HIGH_BANK;
	// RULE11 RULE12 bank joined with low byte
	wire [13:0] direct_addr = access_sel_i ? {bank_q, opcode_addr_i} :
		{access_bank, opcode_addr_i};
	wire is_post = (amode_i == sfa_pkg::AM_POST_INC) || (amode_i == sfa_pkg::AM_POST_DEC);
	wire is_pre = (amode_i == sfa_pkg::AM_PRE_INC);

	// RULE14 long address, RULE17 RULE18 pointer only, RULE19 pre step
	wire [13:0] addr_d = (amode_i == sfa_pkg::AM_DIRECT) ? direct_addr :
		(amode_i == sfa_pkg::AM_LONG) ? long_addr_i :
		is_pre ? ptr_inc :
		(amode_i == sfa_pkg::AM_WORK_OFS) ? ptr_work : ptr_cur;

	wire ptr_adjust = addr_req_i && ptr_ok && (is_post || is_pre);
	// RULE19 post step after access
	wire [13:0] ptr_new = (amode_i == sfa_pkg::AM_POST_DEC) ? ptr_dec : ptr_inc;

	always_comb
	begin
		for (int i = 0; i < PTR_COUNT; i++)
		begin
			ptr_d[i] = ptr_q[i];
			if (apb_wr && (paddr_i == ptr_ofs(i, 1'b0)))
				ptr_d[i][7:0] = pwdata_i[7:0];
			// RULE16 top two bits dropped
			if (apb_wr && (paddr_i == ptr_ofs(i, 1'b1)))
				ptr_d[i][13:8] = pwdata_i[5:0];
			if (ptr_adjust && (int'(ptr_sel_i) == i))
				ptr_d[i] = ptr_new;
		end
	end

	always_ff @(posedge clock_i)
	begin
		for (int i = 0; i < PTR_COUNT; i++)
		begin
			if (srst_i)
				ptr_q[i] <= sfa_pkg::PTR_POR;
			else
				ptr_q[i] <= ptr_d[i];
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			data_addr_q <= 14'h0000;
			addr_valid_q <= 1'b0;
		end
		else
		begin
			addr_valid_q <= addr_req_i;
			if (addr_req_i)
				data_addr_q <= addr_d;
		end
	end

	assign data_addr_o = data_addr_q;
	assign addr_valid_o = addr_valid_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	chk_msb_reads_zero: assert property ( // RULE1
		apb_access && !pwrite_i && hit_status |-> prdata_o[7] == 1'b0)
		else $error("status bit 7 read back nonzero");
	chk_timeout_clear: assert property ( // RULE2
		wdt_timeout_i |=> !wdt_tmo_q
		##1 (wdt_tmo_q == ($past(wdt_clear_i || sleep_i) && !$past(wdt_timeout_i))))
		else $error("timeout indicator wrong after watchdog event");
	chk_sleep_pwrdn: assert property ( // RULE3
		sleep_i && !wdt_clear_i |=> !pwrdn_q && wdt_tmo_q == !$past(wdt_timeout_i))
		else $error("sleep did not clear power-down indicator");
	chk_add_carry: assert property ( // RULE8
		op_valid_i && op_kind_i == sfa_pkg::OP_ADD
		|=> carry_q == $past(({1'b0, op_a_i} + {1'b0, op_b_i}) > 9'h0ff))
		else $error("add carry wrong");
	chk_sub_borrow: assert property ( // RULE9
		op_valid_i && op_kind_i == sfa_pkg::OP_SUB
		|=> carry_q == $past(op_a_i >= op_b_i) && zero_q == $past(op_a_i == op_b_i))
		else $error("subtract borrow or zero wrong");
	chk_neg_msb: assert property ( // RULE4
		op_valid_i |=> neg_q == result_o[7])
		else $error("negative flag does not follow result msb");
	chk_status_dest: assert property ( // RULE22
		op_valid_i && dest_sel_i && dest_is_status_i |=> !file_we_o && !wreg_we_o)
		else $error("result written despite status destination");
	chk_bank_direct: assert property ( // RULE12
		addr_req_i && amode_i == sfa_pkg::AM_DIRECT && access_sel_i
		|=> addr_valid_o && data_addr_o == {$past(bank_q), $past(opcode_addr_i)})
		else $error("banked direct address wrong");
	chk_post_inc: assert property ( // RULE19
		addr_req_i && amode_i == sfa_pkg::AM_POST_INC && ptr_sel_i == 2'd0
		|=> data_addr_o == $past(ptr_q[0]) && ptr_q[0] == 14'($past(ptr_q[0]) + 14'h0001))
		else $error("post-increment order wrong");
	chk_ptr_no_flags: assert property ( // RULE21
		addr_req_i && !op_valid_i && !apb_wr |=> $stable(arith_status_o[4:0]))
		else $error("pointer step disturbed flags");

	cov_sub_op: cover property (op_valid_i && op_kind_i == sfa_pkg::OP_SUB);
	cov_pre_inc: cover property (addr_req_i && amode_i == sfa_pkg::AM_PRE_INC);
	cov_sleep_then_clear: cover property (sleep_i ##[1:8] wdt_clear_i);

endmodule // sfa_core

/* File: verification/sfa_dmem_model.sv */
// sfa_dmem_model: data memory side, records each address handed to it
// assumes: address and valid pulse come registered on clock_i
`timescale 1ns/1ps

module sfa_dmem_model
(
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// address from the core
	input wire logic [13:0] addr_i,
	input wire logic valid_i,
	// capture
	output logic [13:0] last_addr_o,
	output int hits_o
);
	// ------
	// capture
	// ------
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			last_addr_o <= 14'h0000;
			hits_o <= 0;
		end
		else if (valid_i)
		begin
			last_addr_o <= addr_i;
			hits_o <= hits_o + 1;
		end
	end
endmodule // sfa_dmem_model

/* File: verification/tb_status_flags_and_data_addressing.sv */
// tb_status_flags_and_data_addressing: self-checking bench of sfa_core
// assumes: sfa_pkg, sfa_core and sfa_dmem_model compiled first
`timescale 1ns/1ps

module tb_status_flags_and_data_addressing;
	// ------
	// signals
	// ------
	localparam logic [11:0] ST = sfa_pkg::OFS_ARITH_STATUS;
	logic clock_i, srst_i, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rng, v, r;
	logic op_valid, dest_sel, dest_is_status, file_we, wreg_we;
	logic [2:0] op_kind, amode;
	logic [7:0] op_a, op_b, result, opcode_addr, working, status;
	logic wdt_clear, sleep_e, wdt_tmo, addr_req, access_sel, addr_valid;
	logic [13:0] long_addr, data_addr, seen_addr;
	logic [1:0] ptr_sel;
	int n_mismatch, total_checks, hits, i;
	logic [4:0] m_flags;
	logic m_to, m_pd;
	logic [5:0] m_bank;
	logic [13:0] m_ptr [3];

	sfa_core dut (.clock_i(clock_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .op_valid_i(op_valid), .op_kind_i(op_kind),
		.op_a_i(op_a), .op_b_i(op_b), .dest_sel_i(dest_sel), .dest_is_status_i(dest_is_status),
		.result_o(result), .file_we_o(file_we), .wreg_we_o(wreg_we), .wdt_clear_i(wdt_clear),
		.sleep_i(sleep_e), .wdt_timeout_i(wdt_tmo), .addr_req_i(addr_req), .amode_i(amode),
		.opcode_addr_i(opcode_addr), .access_sel_i(access_sel), .long_addr_i(long_addr),
		.ptr_sel_i(ptr_sel), .working_i(working), .data_addr_o(data_addr),
		.addr_valid_o(addr_valid), .arith_status_o(status));

	sfa_dmem_model dmem (.clock_i(clock_i), .srst_i(srst_i), .addr_i(data_addr),
		.valid_i(addr_valid), .last_addr_o(seen_addr), .hits_o(hits));

	initial
	begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	// ------
	// helpers
	// ------
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic logic [7:0] m_status();
		return {1'b0, m_to, m_pd, m_flags};
	endfunction

	function automatic logic [11:0] pa(input int n, input logic hi);
		return sfa_pkg::OFS_PTR_BASE + 12'(n) * sfa_pkg::OFS_PTR_STRIDE
			+ (hi ? sfa_pkg::OFS_PTR_HIGH : 12'h000);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------
	// apb master
	// ------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock_i);
		penable <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge clock_i);
			if (pready === 1'b1)
				break;
		end
		if (k == 50)
		begin
			n_mismatch++;
			finish_test();
		end
		else
		begin
			r = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, exp);
	endtask

	// ------
	// alu, events, addressing
	// ------
	task automatic alu(input logic [2:0] k, input logic [7:0] a, input logic [7:0] b,
		input logic d, input logic st);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] bb;
		logic sb;
		sb = (k == sfa_pkg::OP_SUB);
		bb = sb ? ~b : b;
		s = {1'b0, a} + {1'b0, bb} + {8'h00, sb};
		h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sb};
		case (k)
			sfa_pkg::OP_AND: s = {1'b0, a & b};
			sfa_pkg::OP_OR: s = {1'b0, a | b};
			sfa_pkg::OP_XOR: s = {1'b0, a ^ b};
			sfa_pkg::OP_ROT_LEFT_C: s = {a, m_flags[0]};
			sfa_pkg::OP_ROT_RIGHT_C: s = {a[0], m_flags[0], a[7:1]};
			sfa_pkg::OP_PASS: s = {1'b0, a};
			default: ;
		endcase
		m_flags[4] = s[7];
		m_flags[2] = (s[7:0] == 8'h00);
		if (k <= sfa_pkg::OP_SUB)
		begin
			m_flags[3] = (a[7] == bb[7]) && (s[7] != a[7]);
			m_flags[1] = h[4];
		end
		if (k <= sfa_pkg::OP_SUB || k == sfa_pkg::OP_ROT_LEFT_C || k == sfa_pkg::OP_ROT_RIGHT_C)
			m_flags[0] = s[8];
		@(posedge clock_i);
		op_valid <= 1'b1;
		op_kind <= k;
		op_a <= a;
		op_b <= b;
		dest_sel <= d;
		dest_is_status <= st;
		@(posedge clock_i);
		op_valid <= 1'b0;
		#1;
		if (!st)
			chk(result, s[7:0]);
		chk(file_we, d && !st);
		chk(wreg_we, !d);
		chk(status, m_status());
	endtask

	task automatic ev(input int w);
		@(posedge clock_i);
		wdt_clear <= (w == 0);
		sleep_e <= (w == 1);
		wdt_tmo <= (w == 2);
		@(posedge clock_i);
		wdt_clear <= 1'b0;
		sleep_e <= 1'b0;
		wdt_tmo <= 1'b0;
		#1;
		m_to = (w != 2);
		m_pd = (w == 0) ? 1'b1 : (w == 1) ? 1'b0 : m_pd;
		chk(status, m_status());
	endtask

	task automatic adr(input logic [2:0] m, input logic [7:0] f, input logic as,
		input logic [13:0] lg, input int p, input logic [7:0] w);
		logic [13:0] e;
		logic [5:0] ab;
		e = m_ptr[p];
		ab = (f < sfa_pkg::ACCESS_SPLIT) ? sfa_pkg::ACCESS_LOW_BANK : sfa_pkg::ACCESS_HIGH_BANK;
		case (m)
			sfa_pkg::AM_DIRECT: e = as ? {m_bank, f} : {ab, f};
			sfa_pkg::AM_LONG: e = lg;
			sfa_pkg::AM_POST_INC: m_ptr[p] = m_ptr[p] + 14'h0001;
			sfa_pkg::AM_POST_DEC: m_ptr[p] = m_ptr[p] - 14'h0001;
			sfa_pkg::AM_PRE_INC:
			begin
				m_ptr[p] = m_ptr[p] + 14'h0001;
				e = m_ptr[p];
			end
			sfa_pkg::AM_WORK_OFS: e = m_ptr[p] + {{6{w[7]}}, w};
			default: ;
		endcase
		@(posedge clock_i);
		addr_req <= 1'b1;
		amode <= m;
		opcode_addr <= f;
		access_sel <= as;
		long_addr <= lg;
		ptr_sel <= 2'(p);
		working <= w;
		@(posedge clock_i);
		addr_req <= 1'b0;
		#1;
		chk(data_addr, e);
		chk(addr_valid, 1'b1);
		@(posedge clock_i);
		#1;
		chk(seen_addr, e);
		rdc(pa(p, 0), {24'h0, m_ptr[p][7:0]});
		rdc(pa(p, 1), {26'h0, m_ptr[p][13:8]});
		rdc(ST, {24'h0, m_status()});
	endtask

	// ------
	// main sequence
	// ------
	initial
	begin
		{srst_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		{op_valid, op_kind, op_a, op_b, dest_sel, dest_is_status} = 22'h0;
		{wdt_clear, sleep_e, wdt_tmo, addr_req, amode, opcode_addr} = 15'h0;
		{access_sel, long_addr, ptr_sel, working} = 25'h0;
		{n_mismatch, total_checks} = 0;
		rng = 32'h163a_9c6d;
		{m_flags, m_to, m_pd, m_bank} = {5'h00, 2'b11, 6'h00};
		m_ptr = '{default: 14'h0000};
		repeat (3) @(posedge clock_i);
		srst_i <= 1'b0;
		#1;
		chk(status, 8'h60);
		rdc(ST, 32'h0000_0060);
		$display("test reset done");
		apb(1'b1, ST, 32'hffff_ffff);
		m_flags = 5'h1f;
		rdc(ST, {24'h0, m_status()});
		apb(1'b1, 12'h0f0, 32'h0000_00a5);
		chk(err, 1'b1);
		rdc(12'h0f0, 32'h0000_0000);
		chk(err, 1'b1);
		for (i = 0; i < 3; i++)
		begin
			v = xs();
			m_ptr[i] = v[13:0];
			apb(1'b1, pa(i, 0), {24'h0, v[7:0]});
			apb(1'b1, pa(i, 1), {24'h0, v[15:8]});
			rdc(pa(i, 1), {26'h0, v[13:8]});
			chk(err, 1'b0);
		end
		v = xs();
		m_bank = v[5:0];
		apb(1'b1, sfa_pkg::OFS_BANK_SELECT, {26'h0, v[5:0]});
		rdc(sfa_pkg::OFS_BANK_SELECT, {26'h0, v[5:0]});
		$display("test registers done");
		alu(sfa_pkg::OP_ADD, 8'h7f, 8'h01, 1'b1, 1'b0);
		alu(sfa_pkg::OP_SUB, 8'h80, 8'h01, 1'b0, 1'b0);
		alu(sfa_pkg::OP_SUB, 8'h05, 8'h05, 1'b1, 1'b0);
		alu(sfa_pkg::OP_ADD, 8'hff, 8'h01, 1'b0, 1'b0);
		alu(sfa_pkg::OP_SUB, 8'h10, 8'h21, 1'b0, 1'b0);
		alu(sfa_pkg::OP_ADD, 8'h0f, 8'h01, 1'b1, 1'b1);
		for (i = 0; i < 60; i++)
		begin
			v = xs();
			alu(3'(v[26:24]), v[7:0], v[15:8], v[16], v[17] & v[16]);
		end
		$display("test alu done");
		for (i = 0; i < 6; i++)
			ev((i * 2) % 3);
		$display("test events done");
		m_ptr[0] = 14'h00ff;
		apb(1'b1, pa(0, 0), 32'h0000_00ff);
		apb(1'b1, pa(0, 1), 32'h0000_0000);
		adr(sfa_pkg::AM_POST_INC, 8'h00, 1'b0, 14'h0000, 0, 8'h00);
		m_ptr[1] = 14'h0000;
		apb(1'b1, pa(1, 0), 32'h0000_0000);
		apb(1'b1, pa(1, 1), 32'h0000_0000);
		adr(sfa_pkg::AM_POST_DEC, 8'h00, 1'b1, 14'h0000, 1, 8'h00);
		for (i = 0; i < 35; i++)
		begin
			v = xs();
			adr(3'(i % 7), v[7:0], v[8], v[29:16], v[31:30] % 3, v[15:8]);
		end
		chk(hits, 37);
		$display("test addressing done");
		finish_test();
	end
endmodule // tb_status_flags_and_data_addressing
